// ---- logic/ppx_regs.v ----
// Purpose: Host I/O registers for the palette port and the extended configuration bank
// Assumes: One-cycle read/write strobes synchronous to mclk_i; straps stable at reset release
// Notes: Read data is registered and valid the cycle after the read strobe
`timescale 1ns/1ps
`include "ppx_regs.vh"

// How it works
// R1 - Status shows 00 writing, 11 reading
// R2 - Read index written at status port
// R3 - Write index readable and writable
// R4 - Third colour write commits, bumps index
// R5 - Third colour read bumps read index
// R6 - Pixel ANDed with mask before lookup
// R7 - Six-bit index selects extended data register
// R8 - Key write unlocks, reads unlocked ID
// R9 - Other write locks, reads locked ID
// R10 - Graphics mode holds eight enables
// R11 - Misc zero: prefetch, feature, DAC, clock
// R12 - Threshold registers hold two nibbles each
// R13 - Overflow supplies offset and vertical bit10
// R14 - Two-bit memory-mapped window select
// R15 - Misc one: byte order and enables
// R16 - Two-bit memory configuration field
// R17 - Misc two: access, cache, test, reset
// R18 - Strap zero reports pulled-up pins
// R19 - Strap bit selects subsystem port
// R20 - Strap one: polarity, module, irq, function
// R21 - Locked bank ignores non-password writes
// R22 - Reserved bits and empty indices read zero
module ppx_regs #(
  parameter [7:0] ID_UNLOCKED = 8'h5a, // Arbitrary value
  parameter [7:0] ID_LOCKED = 8'h3c // Arbitrary value
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire [15:0] io_addr_i,
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [7:0] io_wdata_i,
  output reg [7:0] io_rdata_o,
  input wire [13:0] memory_data_straps_i,
  input wire [7:0] pixel_i,
  output wire [7:0] lut_addr_o,
  input wire [17:0] lut_rdata_i,
  output wire [7:0] lut_raddr_o,
  output reg lut_we_o,
  output reg [7:0] lut_waddr_o,
  output reg [17:0] lut_wdata_o,
  output wire [7:0] graphics_mode_o,
  output wire [7:0] misc_control_zero_o,
  output wire [3:0] thr_crt_cpu_low_o,
  output wire [3:0] thr_crt_engine_high_o,
  output wire [3:0] thr_ascii_attr_o,
  output wire [3:0] thr_crt_cpu_high_o,
  output wire [3:0] screen_offset_hi_o,
  output wire [3:0] vert_bit10_o,
  output wire rgb_blue_first_o,
  output wire [1:0] mmio_select_o,
  output wire [4:0] misc_one_enables_o,
  output wire [1:0] memory_config_o,
  output wire [4:0] misc_two_enables_o,
  output wire subsys_port_alt_o,
  output wire ext_unlocked_o
);
  // Palette registers
  reg [7:0] pixel_mask_reg;
  reg [7:0] pal_wr_index_reg;
  reg [7:0] pal_rd_index_reg;
  reg [1:0] pal_status_reg;
  reg [1:0] wr_phase_reg;
  reg [1:0] rd_phase_reg;
  reg [5:0] red_hold_reg;
  reg [5:0] green_hold_reg;
  // Extended bank
  reg [5:0] ext_index_reg;
  reg unlocked_reg;
  reg [7:0] gfx_mode_reg;
  reg [7:0] misc0_reg;
  reg [7:0] thresh0_reg;
  reg [7:0] thresh1_reg;
  reg [7:0] crt_ovf_reg;
  reg [7:0] misc1_reg;
  reg [7:0] misc2_reg;
  reg [7:0] strap0_reg;
  reg [7:0] strap1_reg;
  reg strap_taken_reg;
  reg [7:0] rdata_next;
  reg [5:0] rd_colour;

  wire wr_ext_idx = io_wr_i && (io_addr_i == `PPX_PORT_EXT_INDEX);
  wire wr_ext_dat = io_wr_i && (io_addr_i == `PPX_PORT_EXT_DATA);
  wire wr_mask = io_wr_i && (io_addr_i == `PPX_PORT_PIX_MASK);
  wire wr_rdidx = io_wr_i && (io_addr_i == `PPX_PORT_PAL_RDIDX);
  wire wr_wridx = io_wr_i && (io_addr_i == `PPX_PORT_PAL_WRIDX);
  wire wr_pdata = io_wr_i && (io_addr_i == `PPX_PORT_PAL_DATA);
  wire rd_pdata = io_rd_i && (io_addr_i == `PPX_PORT_PAL_DATA);
  wire wr_pw = wr_ext_dat && (ext_index_reg == `PPX_IDX_PASSWORD);
  // Password is always writable so software can recover a locked bank
  wire wr_bank = wr_ext_dat && unlocked_reg; // R21
  // Per-register enables; all carry the lock gate above
  wire wr_gfx = wr_bank && (ext_index_reg == `PPX_IDX_GFX_MODE);
  wire wr_misc0 = wr_bank && (ext_index_reg == `PPX_IDX_MISC0);
  wire wr_thr0 = wr_bank && (ext_index_reg == `PPX_IDX_THRESH0);
  wire wr_thr1 = wr_bank && (ext_index_reg == `PPX_IDX_THRESH1);
  wire wr_ovf = wr_bank && (ext_index_reg == `PPX_IDX_CRT_OVF);
  wire wr_misc1 = wr_bank && (ext_index_reg == `PPX_IDX_MISC1);
  wire wr_misc2 = wr_bank && (ext_index_reg == `PPX_IDX_MISC2);
  genvar bit_n;

  // Per-bit gate: a cleared mask bit forces that lookup address bit low
  generate
    for (bit_n = 0; bit_n < `PPX_PIX_W; bit_n = bit_n + 1) begin : g_mask
      assign lut_addr_o[bit_n] = pixel_i[bit_n] & pixel_mask_reg[bit_n]; // R6
    end
  endgenerate

  assign lut_raddr_o = pal_rd_index_reg;

  // Palette write sequence: index load restarts phase
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pal_wr_index_reg <= `PPX_RST8;
      wr_phase_reg <= `PPX_PH_RED;
      red_hold_reg <= `PPX_RST6;
      green_hold_reg <= `PPX_RST6;
      lut_we_o <= 1'b0;
      lut_waddr_o <= `PPX_RST8;
      lut_wdata_o <= `PPX_RST18;
    end else begin
      lut_we_o <= 1'b0;
      if (wr_wridx) begin
        pal_wr_index_reg <= io_wdata_i; // R3
        wr_phase_reg <= `PPX_PH_RED;
      end else if (wr_pdata) begin
        case (wr_phase_reg)
          `PPX_PH_RED: begin
            red_hold_reg <= io_wdata_i[`PPX_DAC_BITS];
            wr_phase_reg <= `PPX_PH_GREEN;
          end
          `PPX_PH_GREEN: begin
            green_hold_reg <= io_wdata_i[`PPX_DAC_BITS];
            wr_phase_reg <= `PPX_PH_BLUE;
          end
          default: begin
            lut_we_o <= 1'b1; // R4
            lut_waddr_o <= pal_wr_index_reg;
            lut_wdata_o <= {red_hold_reg, green_hold_reg, io_wdata_i[`PPX_DAC_BITS]};
            pal_wr_index_reg <= pal_wr_index_reg + 8'h01; // R4
            wr_phase_reg <= `PPX_PH_RED;
          end
        endcase
      end
    end
  end

  // Palette read sequence and direction status
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pal_rd_index_reg <= `PPX_RST8;
      rd_phase_reg <= `PPX_PH_RED;
      pal_status_reg <= `PPX_RST2;
      pixel_mask_reg <= `PPX_RST8;
    end else begin
      if (wr_mask) begin
        pixel_mask_reg <= io_wdata_i;
      end
      if (wr_rdidx) begin
        pal_rd_index_reg <= io_wdata_i; // R2
        rd_phase_reg <= `PPX_PH_RED;
        pal_status_reg <= `PPX_STAT_READ; // R1
      end else if (rd_pdata) begin
        if (rd_phase_reg == `PPX_PH_BLUE) begin
          pal_rd_index_reg <= pal_rd_index_reg + 8'h01; // R5
          rd_phase_reg <= `PPX_PH_RED;
        end else begin
          rd_phase_reg <= rd_phase_reg + 2'd1;
        end
      end
      if (wr_wridx) begin
        pal_status_reg <= `PPX_STAT_WRITE; // R1
      end
    end
  end

  // Extended bank index and lock; reset leaves the bank locked
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_index_reg <= `PPX_RST6;
      unlocked_reg <= 1'b0;
    end else begin
      if (wr_ext_idx) begin
        ext_index_reg <= io_wdata_i[`PPX_IDX_BITS]; // R7
      end
      if (wr_pw) begin
        unlocked_reg <= (io_wdata_i == `PPX_KEY); // R8 R9
      end
    end
  end

  // One flop group per bank register keeps each enable visible
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gfx_mode_reg <= `PPX_RST8;
    end else if (wr_gfx) begin
      gfx_mode_reg <= io_wdata_i; // R10
    end
  end

  // Reserved low nibble never stored, so it reads zero
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      misc0_reg <= `PPX_RST8;
    end else if (wr_misc0) begin
      misc0_reg <= io_wdata_i & `PPX_MISC0_MASK; // R11
    end
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thresh0_reg <= `PPX_RST8;
    end else if (wr_thr0) begin
      thresh0_reg <= io_wdata_i; // R12
    end
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thresh1_reg <= `PPX_RST8;
    end else if (wr_thr1) begin
      thresh1_reg <= io_wdata_i; // R12
    end
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crt_ovf_reg <= `PPX_RST8;
    end else if (wr_ovf) begin
      crt_ovf_reg <= io_wdata_i; // R13
    end
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      misc1_reg <= `PPX_RST8;
    end else if (wr_misc1) begin
      misc1_reg <= io_wdata_i; // R14 R15
    end
  end

  // Reserved bit 4 never stored, so it reads zero
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      misc2_reg <= `PPX_RST8;
    end else if (wr_misc2) begin
      misc2_reg <= io_wdata_i & `PPX_MISC2_MASK; // R16 R17
    end
  end

  // Straps caught on the first clock after reset release, never under reset
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_taken_reg <= 1'b0;
      strap0_reg <= `PPX_RST8;
      strap1_reg <= `PPX_RST8;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap0_reg <= memory_data_straps_i[`PPX_STRAP0_BITS]; // R18
      strap1_reg <= {2'b00, memory_data_straps_i[`PPX_STRAP1_BITS]} & `PPX_STRAP1_MASK; // R20
    end
  end

  always @* begin
    case (rd_phase_reg)
      `PPX_PH_RED: begin
        rd_colour = lut_rdata_i[`PPX_CLR_R];
      end
      `PPX_PH_GREEN: begin
        rd_colour = lut_rdata_i[`PPX_CLR_G];
      end
      default: begin
        rd_colour = lut_rdata_i[`PPX_CLR_B];
      end
    endcase
  end

  // Read mux; unmapped ports and empty indices answer zero
  always @* begin
    rdata_next = `PPX_RST8;
    case (io_addr_i)
      `PPX_PORT_EXT_INDEX: begin
        rdata_next = {2'b00, ext_index_reg}; // R22
      end
      `PPX_PORT_PIX_MASK: begin
        rdata_next = pixel_mask_reg;
      end
      `PPX_PORT_PAL_RDIDX: begin
        rdata_next = {6'h00, pal_status_reg}; // R1 R22
      end
      `PPX_PORT_PAL_WRIDX: begin
        rdata_next = pal_wr_index_reg; // R3
      end
      `PPX_PORT_PAL_DATA: begin
        rdata_next = {2'b00, rd_colour}; // R5
      end
      `PPX_PORT_EXT_DATA: begin
        case (ext_index_reg)
          `PPX_IDX_PASSWORD: begin
            rdata_next = unlocked_reg ? ID_UNLOCKED : ID_LOCKED; // R8 R9
          end
          `PPX_IDX_GFX_MODE: begin
            rdata_next = gfx_mode_reg;
          end
          `PPX_IDX_MISC0: begin
            rdata_next = misc0_reg;
          end
          `PPX_IDX_THRESH0: begin
            rdata_next = thresh0_reg;
          end
          `PPX_IDX_THRESH1: begin
            rdata_next = thresh1_reg;
          end
          `PPX_IDX_CRT_OVF: begin
            rdata_next = crt_ovf_reg;
          end
          `PPX_IDX_MISC1: begin
            rdata_next = misc1_reg;
          end
          `PPX_IDX_MISC2: begin
            rdata_next = misc2_reg;
          end
          `PPX_IDX_STRAP0: begin
            rdata_next = strap0_reg;
          end
          `PPX_IDX_STRAP1: begin
            rdata_next = strap1_reg;
          end
          default: rdata_next = `PPX_RST8; // R22
        endcase
      end
      default: rdata_next = `PPX_RST8;
    endcase
  end

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_rdata_o <= `PPX_RST8;
    end else if (io_rd_i) begin
      io_rdata_o <= rdata_next;
    end
  end

  assign graphics_mode_o = gfx_mode_reg; // R10
  assign misc_control_zero_o = misc0_reg; // R11
  assign thr_crt_cpu_low_o = thresh0_reg[`PPX_NIB_HI]; // R12
  assign thr_crt_engine_high_o = thresh0_reg[`PPX_NIB_LO];
  assign thr_ascii_attr_o = thresh1_reg[`PPX_NIB_HI];
  assign thr_crt_cpu_high_o = thresh1_reg[`PPX_NIB_LO];
  assign screen_offset_hi_o = crt_ovf_reg[`PPX_NIB_HI]; // R13
  assign vert_bit10_o = crt_ovf_reg[`PPX_NIB_LO]; // R13
  assign rgb_blue_first_o = misc1_reg[`PPX_MISC1_ORDER]; // R15
  assign mmio_select_o = misc1_reg[`PPX_MISC1_MMIO]; // R14
  assign misc_one_enables_o = misc1_reg[`PPX_MISC1_EN]; // R15
  assign memory_config_o = misc2_reg[`PPX_MISC2_MEMCFG]; // R16
  // Reserved bit 4 and the config field are left out of this bundle
  assign misc_two_enables_o = {
    misc2_reg[`PPX_MISC2_W32],
    misc2_reg[`PPX_MISC2_T16],
    misc2_reg[`PPX_MISC2_CACHE],
    misc2_reg[`PPX_MISC2_TEST],
    misc2_reg[`PPX_MISC2_TGRST]
  }; // R17
  assign subsys_port_alt_o = strap0_reg[`PPX_STRAP0_PORT]; // R19
  assign ext_unlocked_o = unlocked_reg;
endmodule

// ---- common/ppx_regs.vh ----
// Purpose: Port addresses, indices, field positions and reset values for the palette/extended register block
// Assumes: 16-bit I/O address, 8-bit data
// Notes: Definitions only
`ifndef PPX_REGS_VH
`define PPX_REGS_VH
`define PPX_PORT_EXT_INDEX 16'h03c4
`define PPX_PORT_EXT_DATA 16'h03c5
`define PPX_PORT_PIX_MASK 16'h03c6
`define PPX_PORT_PAL_RDIDX 16'h03c7
`define PPX_PORT_PAL_WRIDX 16'h03c8
`define PPX_PORT_PAL_DATA 16'h03c9
`define PPX_IDX_PASSWORD 6'h05
`define PPX_IDX_GFX_MODE 6'h06
`define PPX_IDX_MISC0 6'h07
`define PPX_IDX_THRESH0 6'h08
`define PPX_IDX_THRESH1 6'h09
`define PPX_IDX_CRT_OVF 6'h0a
`define PPX_IDX_MISC1 6'h0b
`define PPX_IDX_MISC2 6'h0c
`define PPX_IDX_STRAP0 6'h0d
`define PPX_IDX_STRAP1 6'h0e
`define PPX_KEY 8'h86
`define PPX_STAT_WRITE 2'b00
`define PPX_STAT_READ 2'b11
`define PPX_RST8 8'h00
`define PPX_RST6 6'h00
`define PPX_RST2 2'b00
`define PPX_PH_RED 2'd0
`define PPX_PH_GREEN 2'd1
`define PPX_PH_BLUE 2'd2
`define PPX_MISC2_MASK 8'hef
`define PPX_MISC0_MASK 8'hf0
`define PPX_STRAP1_MASK 8'h3f
`define PPX_RST18 18'h00000
`define PPX_PIX_W 8
`define PPX_IDX_BITS 5:0
`define PPX_DAC_BITS 5:0
`define PPX_CLR_R 17:12
`define PPX_CLR_G 11:6
`define PPX_CLR_B 5:0
`define PPX_NIB_HI 7:4
`define PPX_NIB_LO 3:0
`define PPX_MISC1_ORDER 7
`define PPX_MISC1_MMIO 6:5
`define PPX_MISC1_EN 4:0
`define PPX_MISC2_W32 7
`define PPX_MISC2_T16 6
`define PPX_MISC2_CACHE 5
`define PPX_MISC2_TEST 3
`define PPX_MISC2_MEMCFG 2:1
`define PPX_MISC2_TGRST 0
`define PPX_STRAP0_BITS 7:0
`define PPX_STRAP1_BITS 13:8
`define PPX_STRAP0_PORT 0
`endif

// ---- dv/ppx_regs_chk.sv ----
// Purpose: Port assertions for ppx_regs
// Assumes: One clock domain
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
module ppx_regs_chk (
  input wire mclk_i,
  input wire nrst_i,
  input wire [15:0] io_addr_i,
  input wire io_wr_i,
  input wire io_rd_i,
  input wire [7:0] io_wdata_i,
  input wire [7:0] io_rdata_o,
  input wire [7:0] pixel_i,
  input wire [7:0] lut_addr_o,
  input wire lut_we_o,
  input wire [17:0] lut_wdata_o,
  input wire [7:0] graphics_mode_o,
  input wire ext_unlocked_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire pw = io_wr_i && io_addr_i == 16'h03c9;
  wire xw = io_wr_i && io_addr_i == 16'h03c5;
  chk_mask_gate: assert property ((lut_addr_o & ~pixel_i) == 8'h00)
    else $error("lut address bit without pixel bit");
  chk_commit_cause: assert property (lut_we_o |-> $past(pw))
    else $error("commit without colour write");
  chk_commit_blue: assert property (lut_we_o |-> lut_wdata_o[5:0] == $past(io_wdata_i[5:0]))
    else $error("committed blue differs");
  chk_commit_pulse: assert property (lut_we_o |=> !lut_we_o)
    else $error("commit pulse too long");
  chk_rdata_hold: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved without read");
  chk_unmapped_zero: assert property (io_rd_i && io_addr_i == 16'h03c0 |=> io_rdata_o == 8'h00)
    else $error("unmapped port read nonzero");
  chk_key_unlock: assert property ($rose(ext_unlocked_o) |-> $past(xw && io_wdata_i == 8'h86))
    else $error("unlock without key");
  chk_other_lock: assert property ($fell(ext_unlocked_o) |-> $past(xw && io_wdata_i != 8'h86))
    else $error("lock without write");
  chk_locked_hold: assert property (!ext_unlocked_o |=> $stable(graphics_mode_o))
    else $error("locked bank changed");
endmodule
bind ppx_regs ppx_regs_chk ppx_regs_chk_inst (.mclk_i, .nrst_i, .io_addr_i, .io_wr_i, .io_rd_i,
  .io_wdata_i, .io_rdata_o, .pixel_i, .lut_addr_o, .lut_we_o, .lut_wdata_o, .graphics_mode_o, .ext_unlocked_o);

// ---- dv/ppx_host_model.sv ----
// Purpose: Host I/O master and colour table for ppx_regs
// Assumes: One strobe cycle per access
// Notes: Idle lines show inverted last value
`timescale 1ns/1ps
module ppx_host_model (
  input wire mclk_i,
  output reg [15:0] a_o = 16'h0000,
  output reg wr_o = 1'b0,
  output reg rd_o = 1'b0,
  output reg [7:0] d_o = 8'h00,
  input wire [7:0] q_i,
  input wire we_i,
  input wire [7:0] wa_i,
  input wire [17:0] wd_i,
  input wire [7:0] ra_i,
  output wire [17:0] rq_o
);
  reg [17:0] colour_lookup_table [0:255];
  always @(posedge mclk_i) begin
    if (we_i) begin
      colour_lookup_table[wa_i] <= wd_i;
    end
  end
  assign rq_o = colour_lookup_table[ra_i];
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge mclk_i);
      a_o <= a;
      d_o <= d;
      wr_o <= 1'b1;
      @(posedge mclk_i);
      wr_o <= 1'b0;
      a_o <= ~a;
      d_o <= ~d;
      #1;
    end
  endtask
  task rd(input [15:0] a, output [7:0] d);
    begin
      @(posedge mclk_i);
      a_o <= a;
      rd_o <= 1'b1;
      @(posedge mclk_i);
      rd_o <= 1'b0;
      a_o <= ~a;
      #1 d = q_i;
    end
  endtask
endmodule

// ---- dv/ppx_regs_tb_top.sv ----
// Purpose: Self-checking bench for ppx_regs
// Assumes: Host model drives the I/O strobes
// Notes: Straps held constant
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module ppx_regs_tb_top;
  localparam [7:0] ID_U = 8'h5a; // Arbitrary value
  localparam [7:0] ID_L = 8'h3c; // Arbitrary value
  localparam [13:0] STRAPS = 14'h2a5b;
  reg mclk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [7:0] pixel_i = 8'h00;
  reg [13:0] straps = STRAPS;
  integer errors = 0;
  integer cmp_count = 0;
  reg [7:0] q, k;
  wire [15:0] a;
  wire w, r, we, bf, sp, ul;
  wire [7:0] d, rq, wa, ra, la, gm, m0;
  wire [17:0] wd, lq;
  wire [3:0] t0, t1, t2, t3, so, vb;
  wire [1:0] mm, mc;
  wire [4:0] e1, e2;
  always #10 mclk_i = ~mclk_i;
  ppx_host_model host (.mclk_i(mclk_i), .a_o(a), .wr_o(w), .rd_o(r), .d_o(d), .q_i(rq), .we_i(we),
    .wa_i(wa), .wd_i(wd), .ra_i(ra), .rq_o(lq));
  ppx_regs #(.ID_UNLOCKED(ID_U), .ID_LOCKED(ID_L)) ppx_regs_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .io_addr_i(a), .io_wr_i(w), .io_rd_i(r), .io_wdata_i(d), .io_rdata_o(rq), .memory_data_straps_i(straps),
    .pixel_i(pixel_i), .lut_addr_o(la), .lut_rdata_i(lq), .lut_raddr_o(ra), .lut_we_o(we), .lut_waddr_o(wa),
    .lut_wdata_o(wd), .graphics_mode_o(gm), .misc_control_zero_o(m0), .thr_crt_cpu_low_o(t0),
    .thr_crt_engine_high_o(t1), .thr_ascii_attr_o(t2), .thr_crt_cpu_high_o(t3), .screen_offset_hi_o(so),
    .vert_bit10_o(vb), .rgb_blue_first_o(bf), .mmio_select_o(mm), .misc_one_enables_o(e1),
    .memory_config_o(mc), .misc_two_enables_o(e2), .subsys_port_alt_o(sp), .ext_unlocked_o(ul));
  task xw(input [5:0] i, input [7:0] v);
    begin
      host.wr(16'h03c4, {2'b00, i});
      host.wr(16'h03c5, v);
    end
  endtask
  task xr(input [5:0] i);
    begin
      host.wr(16'h03c4, {2'b00, i});
      host.rd(16'h03c5, q);
    end
  endtask
  task t_palette;
    begin
      host.rd(16'h03c8, q);
      `CHK(q, 8'h00)
      host.wr(16'h03c8, 8'hff);
      for (k = 0; k < 6; k++) host.wr(16'h03c9, k * 8'd9 + 8'd5);
      host.rd(16'h03c8, q);
      `CHK(q, 8'h01)
      `CHK(host.colour_lookup_table[255], {6'd5, 6'd14, 6'd23})
      `CHK(host.colour_lookup_table[0], {6'd32, 6'd41, 6'd50})
      host.rd(16'h03c7, q);
      `CHK(q, 8'h00)
      host.wr(16'h03c7, 8'hff);
      host.rd(16'h03c7, q);
      `CHK(q, 8'h03)
      for (k = 0; k < 6; k++) begin
        host.rd(16'h03c9, q);
        `CHK(q, k * 8'd9 + 8'd5)
      end
    end
  endtask
  task t_mask;
    begin
      host.wr(16'h03c6, 8'h3c);
      host.rd(16'h03c6, q);
      `CHK(q, 8'h3c)
      @(posedge mclk_i) pixel_i <= 8'he7;
      #1 `CHK(la, 8'h24)
    end
  endtask
  task t_ext;
    begin
      xr(6'h05);
      `CHK(q, ID_L)
      xw(6'h06, 8'h96);
      xr(6'h06);
      `CHK(q, 8'h00)
      xw(6'h05, 8'h86);
      xr(6'h05);
      `CHK(q, ID_U)
      `CHK(ul, 1'b1)
      for (k = 6; k < 15; k++) xw(k[5:0], 8'h96);
      `CHK({gm, m0}, 16'h9690)
      `CHK({t0, t1, t2, t3}, 16'h9696)
      `CHK({so, vb}, 8'h96)
      `CHK({bf, mm, e1}, 8'h96)
      `CHK({mc, e2}, 7'h70)
      xr(6'h07);
      `CHK(q, 8'h90)
      xr(6'h0c);
      `CHK(q, 8'h86)
      xr(6'h0d);
      `CHK(q, STRAPS[7:0])
      `CHK(sp, STRAPS[0])
      xr(6'h0e);
      `CHK(q, {2'b00, STRAPS[13:8]})
      for (k = 0; k < 4; k++) begin
        xw(6'h0b, {1'b0, k[1:0], 5'h00});
        xw(6'h0c, {5'h00, k[1:0], 1'b0});
        `CHK(mm, k[1:0])
        `CHK(mc, k[1:0])
      end
      host.wr(16'h03c4, 8'hff);
      host.rd(16'h03c4, q);
      `CHK(q, 8'h3f)
      host.rd(16'h03c5, q);
      `CHK(q, 8'h00)
      host.rd(16'h03c0, q);
      `CHK(q, 8'h00)
      xw(6'h05, 8'h85);
      xr(6'h05);
      `CHK(q, ID_L)
      `CHK(ul, 1'b0)
      xw(6'h06, 8'h00);
      `CHK(gm, 8'h96)
    end
  endtask
  task close_out;
    begin
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    t_palette;
    t_mask;
    t_ext;
    close_out;
  end
  initial begin
    #100000;
    errors++;
    close_out;
  end
endmodule
